//--- src/sensor_option_bank_decoder.v
// Option bank decoder: samples fused banks 1 to 4 and presents decoded settings.
//
// Function
// - Bank 1 bits 7-6 select halt time: 20 s, 40 s, never, or always with proximity held 40 s.
// - Bank 1 sits at index 0xc5 and its bits 2-0 pick the calibration floor from eight values.
// - The halt and floor settings of bank 1 only take effect while full auto-tuning is selected.
// - Bank 2 bit 7 picks the streaming link: clear for single wire, set for two-wire I2C.
// - Bank 2 sits at 0xc6; bit 6 charge rate, bit 5 link enable, bit 3 tuning goal.
// - Bank 2 bit 2 picks auto-tuning type, zero full and one partial, the latter discouraged.
// - Bank 2 bits 1-0 pick sample cadence of 9, 128, 256 or 512 ms.
// - All eight bits of bank 3 are reserved and steer nothing.
// - Bank 4 bit 3 enables noise suppression; its other bits are reserved.
// - Options live in one-time-programmable fuses, not writable storage.
// - An unprogrammed fuse bit reads as zero, so every field defaults to code zero.
`timescale 1ns/1ps
`include "option_bank_consts.vh"
module sensor_option_bank_decoder (
    input  wire        CLK,
    input  wire        RESET,
    // Fuse programming strobes, one bit per fuse to burn.
    input  wire [7:0]  BURN_BANK1,
    input  wire [7:0]  BURN_BANK2,
    input  wire [7:0]  BURN_BANK3,
    input  wire [7:0]  BURN_BANK4,
    // Wishbone classic slave.
    input  wire        WB_CYC_I,
    input  wire        WB_STB_I,
    input  wire        WB_WE_I,
    input  wire [9:0]  WB_ADR_I,
    input  wire [3:0]  WB_SEL_I,
    input  wire [31:0] WB_DAT_I,
    output reg  [31:0] WB_DAT_O,
    output reg         WB_ACK_O,
    output reg         WB_ERR_O,
    // Decoded settings.
    output reg  [1:0]  HALT_TIME_SELECT,
    output reg  [15:0] HALT_SECONDS,
    output reg         HALT_NEVER,
    output reg         HALT_ALWAYS,
    output reg  [9:0]  CAL_FLOOR,
    output reg         LINK_TWO_WIRE,
    output reg  [9:0]  CHARGE_RATE_KHZ,
    output reg         LINK_ENABLE,
    output reg  [10:0] AUTO_TUNING_GOAL,
    output reg         AUTO_TUNING_PARTIAL,
    output reg  [1:0]  POWER_CADENCE_SELECT,
    output reg  [9:0]  SAMPLE_PERIOD_MS,
    output reg         NOISE_SUPPRESSION_ENABLE,
    output reg         SETTINGS_VALID
);
    // Sampler states: take the banks once, then hold them.
    localparam ST_IDLE = 1'b0;
    localparam ST_HOLD = 1'b1;

    // Fuse image, decoded table values, sampled banks and bus decode.
    wire [31:0] fuse_word;
    wire [9:0]  floor_value;
    wire [9:0]  cadence_ms;
    wire [9:0]  rate_khz;
    wire [10:0] goal_counts;
    reg         state_q;
    reg  [7:0]  bank1_q;
    reg  [7:0]  bank2_q;
    reg  [7:0]  bank3_q;
    reg  [7:0]  bank4_q;
    reg  [7:0]  burn1_q;
    reg  [7:0]  burn2_q;
    reg  [7:0]  burn3_q;
    reg  [7:0]  burn4_q;
    reg  [7:0]  burn1_s;
    reg  [7:0]  burn2_s;
    reg  [7:0]  burn3_s;
    reg  [7:0]  burn4_s;
    reg  [7:0]  idx;
    reg  [31:0] rdata_d;
    reg         hit_d;
    wire        full_tune;
    wire [1:0]  halt_code;
    wire [2:0]  floor_code;
    wire [1:0]  cadence_code;
    wire        discouraged;
    wire        bus_req;

    // Returns the register index of a byte address, or zero when not word aligned.
    function [7:0] word_index;
        input [9:0] adr;
        begin
            if (adr[1:0] != 2'h0) begin
                word_index = 8'h00;
            end else begin
                word_index = adr[9:2];
            end
        end
    endfunction

    // Burn strobes come from pins and pass two flip-flops first.
    always @(posedge CLK) begin
        burn1_q <= BURN_BANK1;
        burn2_q <= BURN_BANK2;
        burn3_q <= BURN_BANK3;
        burn4_q <= BURN_BANK4;
        burn1_s <= burn1_q;
        burn2_s <= burn2_q;
        burn3_s <= burn3_q;
        burn4_s <= burn4_q;
    end

    // Fuses can only be set, never rewritten.
    fuse_bank_array u_fuses (
        .clk        (CLK),
        .burn_bank1 (burn1_s),
        .burn_bank2 (burn2_s),
        .burn_bank3 (burn3_s),
        .burn_bank4 (burn4_s),
        .fuse_word  (fuse_word)
    );

    // Sample all banks once after reset, then hold.
    always @(posedge CLK) begin
        if (RESET) begin
            state_q <= ST_IDLE;
            bank1_q <= `FUSE_RESET;
            bank2_q <= `FUSE_RESET;
            bank3_q <= `FUSE_RESET;
            bank4_q <= `FUSE_RESET;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    bank1_q <= fuse_word[7:0] & `B1_USED_MASK;
                    bank2_q <= fuse_word[15:8] & `B2_USED_MASK;
                    bank3_q <= fuse_word[23:16] & `B3_USED_MASK;
                    bank4_q <= fuse_word[31:24] & `B4_USED_MASK;
                    state_q <= ST_HOLD;
                end
                default: state_q <= ST_HOLD;
            endcase
        end
    end

    // Full auto-tuning is the all-zero code of the tuning type bit.
    assign full_tune = ~bank2_q[`B2_TUNE_BIT];

    // Coded fields of the sampled banks.
    assign floor_code   = bank1_q[`B1_FLOOR_HI:`B1_FLOOR_LO];
    assign cadence_code = bank2_q[`B2_CAD_HI:`B2_CAD_LO];

    // Field value tables.
    option_field_decode u_decode (
        .floor_code   (floor_code),
        .cadence_code (cadence_code),
        .rate_bit     (bank2_q[`B2_RATE_BIT]),
        .goal_bit     (bank2_q[`B2_GOAL_BIT]),
        .floor_value  (floor_value),
        .cadence_ms   (cadence_ms),
        .rate_khz     (rate_khz),
        .goal_counts  (goal_counts)
    );

    // Halt time in seconds for a halt code; the never-halt code reports the long time.
    function [15:0] halt_seconds_of;
        input [1:0] code;
        begin
            if (code == `HALT_20S) begin
                halt_seconds_of = `HALT_SHORT_S;
            end else begin
                halt_seconds_of = `HALT_LONG_S;
            end
        end
    endfunction

    // Bank 1 halt code, forced to code zero under partial tuning.
    assign halt_code = full_tune ? bank1_q[`B1_HALT_HI:`B1_HALT_LO] : `HALT_20S;

    // Halt time select, its two special cases and the time in seconds.
    always @(posedge CLK) begin
        if (RESET) begin
            HALT_TIME_SELECT <= `HALT_20S;
            HALT_SECONDS     <= halt_seconds_of(`HALT_20S);
            HALT_NEVER       <= 1'b0;
            HALT_ALWAYS      <= 1'b0;
        end else begin
            HALT_TIME_SELECT <= halt_code;
            HALT_SECONDS     <= halt_seconds_of(halt_code);
            HALT_NEVER       <= (halt_code == `HALT_NEVER);
            HALT_ALWAYS      <= (halt_code == `HALT_ALWAYS);
        end
    end

    // Calibration floor of bank 1, applied only under full tuning.
    always @(posedge CLK) begin
        if (RESET) begin
            CAL_FLOOR <= `FLOOR_0;
        end else if (full_tune) begin
            CAL_FLOOR <= floor_value;
        end else begin
            CAL_FLOOR <= `FLOOR_0;
        end
    end

    // Streaming link method and enable from bank 2.
    always @(posedge CLK) begin
        if (RESET) begin
            LINK_TWO_WIRE <= 1'b0;
            LINK_ENABLE   <= 1'b0;
        end else begin
            LINK_TWO_WIRE <= bank2_q[`B2_METHOD_BIT];
            LINK_ENABLE   <= bank2_q[`B2_LINK_EN_BIT];
        end
    end

    // Charge rate, tuning goal and tuning type from bank 2.
    always @(posedge CLK) begin
        if (RESET) begin
            CHARGE_RATE_KHZ     <= `RATE_FAST_KHZ;
            AUTO_TUNING_GOAL    <= `GOAL_HIGH;
            AUTO_TUNING_PARTIAL <= 1'b0;
        end else begin
            CHARGE_RATE_KHZ     <= rate_khz;
            AUTO_TUNING_GOAL    <= goal_counts;
            AUTO_TUNING_PARTIAL <= ~full_tune;
        end
    end

    // Sample cadence code and its period from bank 2.
    always @(posedge CLK) begin
        if (RESET) begin
            POWER_CADENCE_SELECT <= 2'h0;
            SAMPLE_PERIOD_MS     <= `CAD_BOOST_MS;
        end else begin
            POWER_CADENCE_SELECT <= cadence_code;
            SAMPLE_PERIOD_MS     <= cadence_ms;
        end
    end

    // Noise suppression from bank 4 and the settings-valid flag.
    always @(posedge CLK) begin
        if (RESET) begin
            NOISE_SUPPRESSION_ENABLE <= 1'b0;
            SETTINGS_VALID           <= 1'b0;
        end else begin
            NOISE_SUPPRESSION_ENABLE <= bank4_q[`B4_NOISE_BIT];
            SETTINGS_VALID           <= (state_q == ST_HOLD);
        end
    end

    // A fused setting that should be avoided: partial tuning or the slowest cadence.
    assign discouraged = (cadence_code == 2'h3) | ~full_tune;

    // Read decode; all banks are read-only.
    always @* begin
        idx     = word_index(WB_ADR_I);
        rdata_d = 32'h0000_0000;
        hit_d   = 1'b1;
        if (idx == `BANK1_IDX) begin
            rdata_d = {24'h000000, bank1_q};
        end else if (idx == `BANK2_IDX) begin
            rdata_d = {24'h000000, bank2_q};
        end else if (idx == `BANK3_IDX) begin
            rdata_d = {24'h000000, bank3_q};
        end else if (idx == `BANK4_IDX) begin
            rdata_d = {24'h000000, bank4_q};
        end else if (idx == `STATUS_IDX) begin
            rdata_d = {29'h00000000,
                       discouraged,
                       full_tune,
                       state_q};
        end else begin
            hit_d = 1'b0;
        end
    end

    // A request is taken when the strobe meets no answer still standing.
    assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O;

    // Acknowledge a mapped read one cycle after the strobe, for one cycle.
    always @(posedge CLK) begin
        if (RESET) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= bus_req & hit_d & ~WB_WE_I;
        end
    end

    // Refuse every write and every unmapped access; the fuses cannot be rewritten.
    always @(posedge CLK) begin
        if (RESET) begin
            WB_ERR_O <= 1'b0;
        end else begin
            WB_ERR_O <= bus_req & (~hit_d | WB_WE_I);
        end
    end

    // Read data stands from its answer until the next request is taken.
    always @(posedge CLK) begin
        if (RESET) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (bus_req) begin
            WB_DAT_O <= (hit_d & ~WB_WE_I) ? rdata_d : 32'h0000_0000;
        end
    end
endmodule // sensor_option_bank_decoder

//--- src/option_bank_consts.vh
// Offsets, field positions, reset values and timing constants of the option bank decoder.
`ifndef OPTION_BANK_CONSTS_VH
`define OPTION_BANK_CONSTS_VH

// Bank indices; the printed offsets are not multiples of four, so byte address = 4 * index.
`define BANK1_IDX            8'hc5
`define BANK2_IDX            8'hc6
`define BANK3_IDX            8'hc7
`define BANK4_IDX            8'hc8
`define STATUS_IDX           8'hc9
`define ADR_BYTES            10

// Bank 1 fields.
`define B1_HALT_HI           7
`define B1_HALT_LO           6
`define B1_FLOOR_HI          2
`define B1_FLOOR_LO          0
`define B1_USED_MASK         8'hc7
// Bank 2 fields.
`define B2_METHOD_BIT        7
`define B2_RATE_BIT          6
`define B2_LINK_EN_BIT       5
`define B2_GOAL_BIT          3
`define B2_TUNE_BIT          2
`define B2_CAD_HI            1
`define B2_CAD_LO            0
`define B2_USED_MASK         8'hef
// Bank 4 fields, then the bank 3 mask.
`define B4_NOISE_BIT         3
`define B4_USED_MASK         8'h08
`define B3_USED_MASK         8'h00

// Unprogrammed fuses read as zero.
`define FUSE_RESET           8'h00

// Halt time codes and times in seconds.
`define HALT_20S             2'h0
`define HALT_40S             2'h1
`define HALT_NEVER           2'h2
`define HALT_ALWAYS          2'h3
`define HALT_SHORT_S         16'h0014
`define HALT_LONG_S          16'h0028

// Calibration floor values.
`define FLOOR_0              10'h0c8
`define FLOOR_1              10'h032
`define FLOOR_2              10'h04b
`define FLOOR_3              10'h064
`define FLOOR_4              10'h096
`define FLOOR_5              10'h0fa
`define FLOOR_6              10'h12c
`define FLOOR_7              10'h1f4

// Charge rates in kHz, tuning goals in counts.
`define RATE_FAST_KHZ        10'h200
`define RATE_SLOW_KHZ        10'h0fa
`define GOAL_HIGH            11'h400
`define GOAL_LOW             11'h200

// Sample cadence periods in ms.
`define CAD_BOOST_MS         10'h009
`define CAD_NORMAL_MS        10'h080
`define CAD_LOW1_MS          10'h100
`define CAD_LOW2_MS          10'h200

// Status register bits.
`define ST_LOADED_BIT        0
`define ST_FULL_TUNE_BIT     1
`define ST_DISCOURAGED_BIT   2

`endif

//--- src/fuse_bank_array.v
// One-time-programmable storage for the four option banks.
`timescale 1ns/1ps
`include "option_bank_consts.vh"
module fuse_bank_array (
    input  wire       clk,
    input  wire [7:0] burn_bank1,
    input  wire [7:0] burn_bank2,
    input  wire [7:0] burn_bank3,
    input  wire [7:0] burn_bank4,
    output wire [31:0] fuse_word
);
    // Fuse image; a burnt fuse reads one, an unprogrammed fuse zero.
    reg [7:0] fuse_q [0:3];
    integer i;

    // Fuses start blank and can only be set, never cleared.
    initial begin
        for (i = 0; i < 4; i = i + 1) begin
            fuse_q[i] = `FUSE_RESET;
        end
    end

    // Burning only ever adds ones, so the contents cannot be rewritten.
    always @(posedge clk) begin
        fuse_q[0] <= fuse_q[0] | burn_bank1;
        fuse_q[1] <= fuse_q[1] | burn_bank2;
        fuse_q[2] <= fuse_q[2] | burn_bank3;
        fuse_q[3] <= fuse_q[3] | burn_bank4;
    end

    assign fuse_word = {fuse_q[3], fuse_q[2], fuse_q[1], fuse_q[0]};
endmodule // fuse_bank_array

//--- src/option_field_decode.v
// Table lookups that turn coded option fields into setting values.
`timescale 1ns/1ps
`include "option_bank_consts.vh"
module option_field_decode (
    input  wire [2:0]  floor_code,
    input  wire [1:0]  cadence_code,
    input  wire        rate_bit,
    input  wire        goal_bit,
    output reg  [9:0]  floor_value,
    output reg  [9:0]  cadence_ms,
    output wire [9:0]  rate_khz,
    output wire [10:0] goal_counts
);
    // Calibration floor table.
    always @* begin
        case (floor_code)
            3'h0: floor_value = `FLOOR_0;
            3'h1: floor_value = `FLOOR_1;
            3'h2: floor_value = `FLOOR_2;
            3'h3: floor_value = `FLOOR_3;
            3'h4: floor_value = `FLOOR_4;
            3'h5: floor_value = `FLOOR_5;
            3'h6: floor_value = `FLOOR_6;
            default: floor_value = `FLOOR_7;
        endcase
    end

    // Sample cadence table.
    always @* begin
        case (cadence_code)
            2'h0: cadence_ms = `CAD_BOOST_MS;
            2'h1: cadence_ms = `CAD_NORMAL_MS;
            2'h2: cadence_ms = `CAD_LOW1_MS;
            default: cadence_ms = `CAD_LOW2_MS;
        endcase
    end

    // Single-bit selections.
    assign rate_khz    = rate_bit ? `RATE_SLOW_KHZ : `RATE_FAST_KHZ;
    assign goal_counts = goal_bit ? `GOAL_LOW : `GOAL_HIGH;
endmodule // option_field_decode

//--- tb/option_bank_chk.sv
// Concurrent checks on the option bank decoder ports.
`timescale 1ns/1ps
module option_bank_chk (
    input wire        CLK,
    input wire        RESET,
    input wire        WB_CYC_I,
    input wire        WB_STB_I,
    input wire        WB_WE_I,
    input wire [9:0]  WB_ADR_I,
    input wire [31:0] WB_DAT_O,
    input wire        WB_ACK_O,
    input wire        WB_ERR_O,
    input wire [1:0]  HALT_TIME_SELECT,
    input wire [15:0] HALT_SECONDS,
    input wire        HALT_NEVER,
    input wire        HALT_ALWAYS,
    input wire [9:0]  CAL_FLOOR,
    input wire        AUTO_TUNING_PARTIAL,
    input wire [1:0]  POWER_CADENCE_SELECT,
    input wire [9:0]  SAMPLE_PERIOD_MS,
    input wire        SETTINGS_VALID
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    // A taken request is answered exactly one cycle later, and only for one cycle.
    a_ack_timing: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O
        |=> WB_ACK_O ^ WB_ERR_O) else $error("bus answer late or doubled");
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    // Fused banks cannot be written, so every write is refused.
    a_write_refused: assert property (WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O
        && !WB_ERR_O |=> WB_ERR_O && !WB_ACK_O) else $error("write not refused");
    // Reads succeed only at mapped places and carry one byte.
    a_read_mapped: assert property (WB_ACK_O |-> !$past(WB_WE_I) && WB_DAT_O[31:8] == 24'h0
        && $past(WB_ADR_I) inside {10'h314, 10'h318, 10'h31c, 10'h320, 10'h324})
        else $error("ack for unmapped access");
    a_halt_flags: assert property (HALT_NEVER == (HALT_TIME_SELECT == 2'h2)
        && HALT_ALWAYS == (HALT_TIME_SELECT == 2'h3)) else $error("halt flags wrong");
    a_halt_seconds: assert property (HALT_TIME_SELECT != 2'h2
        |-> HALT_SECONDS == (HALT_TIME_SELECT[0] ? 16'h0028 : 16'h0014))
        else $error("halt seconds wrong");
    // Partial tuning leaves bank 1 at its code-zero settings.
    a_partial_forces: assert property (AUTO_TUNING_PARTIAL
        |-> CAL_FLOOR == 10'h0c8 && HALT_TIME_SELECT == 2'h0) else $error("bank 1 applied");
    a_cadence_map: assert property (SAMPLE_PERIOD_MS == (POWER_CADENCE_SELECT == 2'h0
        ? 10'h009 : 10'h040 << POWER_CADENCE_SELECT)) else $error("cadence period wrong");
    a_settings_hold: assert property (SETTINGS_VALID |=> $stable(CAL_FLOOR)
        && $stable(SAMPLE_PERIOD_MS) && $stable(HALT_TIME_SELECT)
        && $stable(AUTO_TUNING_PARTIAL)) else $error("settings moved while valid");
endmodule // option_bank_chk

bind sensor_option_bank_decoder option_bank_chk option_bank_chk_inst (
    .CLK(CLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .WB_ERR_O(WB_ERR_O), .HALT_TIME_SELECT(HALT_TIME_SELECT), .HALT_SECONDS(HALT_SECONDS),
    .HALT_NEVER(HALT_NEVER), .HALT_ALWAYS(HALT_ALWAYS), .CAL_FLOOR(CAL_FLOOR),
    .AUTO_TUNING_PARTIAL(AUTO_TUNING_PARTIAL), .POWER_CADENCE_SELECT(POWER_CADENCE_SELECT),
    .SAMPLE_PERIOD_MS(SAMPLE_PERIOD_MS), .SETTINGS_VALID(SETTINGS_VALID));

//--- tb/tb.sv
// Self-checking bench for the option bank decoder.
`timescale 1ns/1ps
module tb;
    localparam [79:0] FLOORS = {10'h1f4, 10'h12c, 10'h0fa, 10'h096,
                                10'h064, 10'h04b, 10'h032, 10'h0c8};
    reg         clk, rst, cyc, stb, we;
    reg  [9:0]  adr;
    reg  [7:0]  b1, b2, b3, b4;
    wire [31:0] dat;
    wire        ack, err, hnev, halw, two, len, part, noise, vld;
    wire [1:0]  hsel, cad;
    wire [15:0] hsec;
    wire [9:0]  flr, rate, per;
    wire [10:0] goal;
    integer     err_count, n_checks;

    sensor_option_bank_decoder sensor_option_bank_decoder_inst (
        .CLK(clk), .RESET(rst), .BURN_BANK1(b1), .BURN_BANK2(b2), .BURN_BANK3(b3),
        .BURN_BANK4(b4), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hf), .WB_DAT_I(32'h0000_00ff), .WB_DAT_O(dat), .WB_ACK_O(ack),
        .WB_ERR_O(err), .HALT_TIME_SELECT(hsel), .HALT_SECONDS(hsec), .HALT_NEVER(hnev),
        .HALT_ALWAYS(halw), .CAL_FLOOR(flr), .LINK_TWO_WIRE(two), .CHARGE_RATE_KHZ(rate),
        .LINK_ENABLE(len), .AUTO_TUNING_GOAL(goal), .AUTO_TUNING_PARTIAL(part),
        .POWER_CADENCE_SELECT(cad), .SAMPLE_PERIOD_MS(per),
        .NOISE_SUPPRESSION_ENABLE(noise), .SETTINGS_VALID(vld));

    // Compares one value and counts it.
    task chk(input [8*6-1:0] nm, input [31:0] e, input [31:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("MISMATCH %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    // One classic Wishbone cycle, then compares the answer kind and read data.
    task bus(input [9:0] a, input w, input e_err, input [31:0] e_dat);
        integer n;
        begin
            @(posedge clk);
            cyc <= 1'b1;
            stb <= 1'b1;
            adr <= a;
            we <= w;
            n = 0;
            while (ack !== 1'b1 && err !== 1'b1 && n < 20) begin
                @(posedge clk);
                n = n + 1;
            end
            chk("ans", 1, {31'h0, ack | err});
            chk("err", {31'h0, e_err}, {31'h0, err});
            if (!e_err) chk("rdata", e_dat, dat);
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask

    // Raises burn pins for a few cycles; fuse bits are sticky.
    task burn(input [7:0] x1, input [7:0] x2, input [7:0] x3, input [7:0] x4);
        begin
            @(posedge clk);
            b1 <= x1;
            b2 <= x2;
            b3 <= x3;
            b4 <= x4;
            repeat (5) @(posedge clk);
            {b1, b2, b3, b4} <= 32'h0;
        end
    endtask

    // Ten cycles of reset, then waits for the settings to be sampled.
    task do_reset;
        integer n;
        begin
            @(posedge clk);
            rst <= 1'b1;
            repeat (10) @(posedge clk);
            chk("vldrst", 0, vld);
            rst <= 1'b0;
            n = 0;
            while (vld !== 1'b1 && n < 10) begin
                @(posedge clk);
                n = n + 1;
            end
            chk("vld", 1, vld);
        end
    endtask

    // Works out every setting and readback from the fused bank contents.
    task check_all(input [7:0] k1, input [7:0] k2, input [7:0] k4);
        reg [1:0] h;
        reg [2:0] f;
        begin
            h = k2[2] ? 2'h0 : k1[7:6];
            f = k2[2] ? 3'h0 : k1[2:0];
            chk("hsel", h, hsel);
            if (h != 2'h2) chk("hsec", h[0] ? 40 : 20, hsec);
            chk("halt", {h == 2'h2, h == 2'h3}, {hnev, halw});
            chk("floor", FLOORS[f*10 +: 10], flr);
            chk("two", k2[7], two);
            chk("rate", k2[6] ? 250 : 512, rate);
            chk("len", k2[5], len);
            chk("goal", k2[3] ? 512 : 1024, goal);
            chk("part", k2[2], part);
            chk("cad", k2[1:0], cad);
            chk("per", k2[1:0] == 2'h0 ? 9 : 64 << k2[1:0], per);
            chk("noise", k4[3], noise);
            bus(10'h314, 1'b0, 1'b0, k1 & 8'hc7);
            bus(10'h318, 1'b0, 1'b0, k2 & 8'hef);
            bus(10'h31c, 1'b0, 1'b0, 32'h0);
            bus(10'h320, 1'b0, 1'b0, k4 & 8'h08);
            bus(10'h324, 1'b0, 1'b0, {k2[2] | &k2[1:0], !k2[2], 1'b1});
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", n_checks, err_count);
            if (err_count == 0 && n_checks > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask

    // Free-running 10 MHz clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Cuts a hang short.
    initial begin
        repeat (5000) @(posedge clk);
        err_count = err_count + 1;
        end_sim;
    end

    // Main sequence; fuses only accumulate, so each step adds bits.
    initial begin
        {rst, cyc, stb, we, adr, b1, b2, b3, b4} = {1'b1, 45'h0};
        err_count = 0;
        n_checks = 0;
        do_reset;
        check_all(8'h00, 8'h00, 8'h00);
        bus(10'h314, 1'b1, 1'b1, 32'h0);
        bus(10'h000, 1'b0, 1'b1, 32'h0);
        bus(10'h328, 1'b0, 1'b1, 32'h0);
        $display("test defaults done");
        burn(8'h79, 8'h19, 8'hff, 8'hf7);
        do_reset;
        check_all(8'h79, 8'h19, 8'hf7);
        $display("test reserved bits done");
        burn(8'h00, 8'h80, 8'h00, 8'h00);
        chk("late", 0, two);
        do_reset;
        check_all(8'h79, 8'h99, 8'hf7);
        $display("test late burn done");
        burn(8'hc7, 8'h62, 8'h00, 8'h08);
        do_reset;
        check_all(8'hff, 8'hfb, 8'hff);
        $display("test full tuning done");
        burn(8'h00, 8'h04, 8'h00, 8'h00);
        do_reset;
        check_all(8'hff, 8'hff, 8'hff);
        $display("test partial tuning done");
        end_sim;
    end
endmodule // tb
